// ### sapc_afe_model.sv
`timescale 1ns/1ps
module sapc_afe_model (
    // front end view
    input wire pclk,
    input wire hold,
    input wire [15:0] dac_trial,
    input wire [15:0] vin,
    output reg cmp_hi
);
    reg [15:0] held = 16'h0;
    // track input until held
    always @(posedge pclk) begin
        if (!hold)
            held <= vin;
    end
    // comparator, offset binary
    always @* cmp_hi = held >= dac_trial;
endmodule

// ### sapc_ctrl.v
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "sapc_defs.vh"
module sapc_ctrl #(
    parameter WIDTH = 16
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    // host strobes, async pins
    input wire select_n,
    input wire read_conv,
    input wire byte_swap,
    // parallel result port
    output reg [WIDTH-1:0] result_lines,
    output reg result_lines_oe_n,
    output reg busy_n,
    // analog front end
    output reg hold,
    output reg [WIDTH-1:0] dac_trial,
    input wire cmp_hi
);
    //////////////////////////////////////////////////////////////////
    // pin synchronisers
    reg [2:0] sync1;
    reg [2:0] sync2;
    reg cs_q;
    reg rc_q;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            cs_q <= 1'b1;
            rc_q <= 1'b1;
        end else begin
            sync1 <= {byte_swap, read_conv, select_n};
            sync2 <= sync1;
            cs_q <= sync2[0];
            rc_q <= sync2[1];
        end
    end
    wire cs_s = sync2[0];
    wire rc_s = sync2[1];
    wire bs_s = sync2[2];
    // strobes are or-combined: start when the or falls
    wire strobe = cs_s | rc_s;
    wire strobe_q = cs_q | rc_q;
    wire start_req = strobe_q & ~strobe;
    // read enable on rc rise with cs low or cs fall with rc high
    wire rd_edge = (~cs_s & rc_s) & ~(~cs_q & rc_q);
    //////////////////////////////////////////////////////////////////
    // conversion control
    localparam ST_IDLE = 2'h0;
    localparam ST_CONV = 2'h1;
    reg [1:0] state;
    reg [1:0] next_state;
    reg [WIDTH-1:0] latch;
    reg ctrl_soft;
    reg ctrl_hold;
    reg [1:0] irq_stat;
    reg [1:0] irq_mask;
    reg [15:0] conv_cnt;
    reg soft_go;
    reg rearm;
    wire sar_done;
    wire [WIDTH-1:0] sar_word;
    wire [WIDTH-1:0] sar_trial;
    // both strobes still low when busy rises: start again at once
    wire go = (start_req | soft_go | rearm) & ~ctrl_hold;
    wire accept = go & (state == ST_IDLE);
    wire reject = go & (state != ST_IDLE);
    sapc_sar #(
        .WIDTH(WIDTH),
        .BIT_CYC(`SAPC_CONV_CYC / WIDTH)
    ) u_sar (
        .pclk(pclk),
        .presetn(presetn),
        .start(accept),
        .done(sar_done),
        .word(sar_word),
        .trial(sar_trial),
        .cmp_hi(cmp_hi)
    );
    // next state
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (sar_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end
    // state, latch, busy, hold
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            latch <= {WIDTH{1'b0}};
            busy_n <= 1'b1;
            hold <= 1'b0;
            dac_trial <= {WIDTH{1'b0}};
            conv_cnt <= 16'h0000;
            rearm <= 1'b0;
        end else begin
            state <= next_state;
            rearm <= sar_done & ~strobe;
            dac_trial <= sar_trial;
            if (accept) begin
                busy_n <= 1'b0;
                hold <= 1'b1;
            end else if (sar_done) begin
                latch <= sar_word;
                busy_n <= 1'b1;
                hold <= 1'b0;
                conv_cnt <= conv_cnt + 16'h0001;
            end
        end
    end
    // latch and busy update on the same edge, the new word shows on result_lines one cycle after busy has risen
    //////////////////////////////////////////////////////////////////
    // output port
    reg out_en;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_en <= 1'b0;
            result_lines <= {WIDTH{1'b0}};
            result_lines_oe_n <= 1'b1;
        end else begin
            if (cs_s | ~rc_s) begin
                out_en <= 1'b0;
            end else if (rd_edge) begin
                out_en <= 1'b1;
            end
            result_lines_oe_n <= ~(out_en & ~cs_s & rc_s);
            if (bs_s) begin
                result_lines <= {latch[WIDTH/2-1:0], latch[WIDTH-1:WIDTH/2]};
            end else begin
                result_lines <= latch;
            end
        end
    end
    //////////////////////////////////////////////////////////////////
    // apb registers
    wire wr = psel & penable & pwrite;
    wire rd = psel & penable & ~pwrite;
    wire hit = (paddr == `SAPC_ADDR_CTRL) | (paddr == `SAPC_ADDR_STAT) | (paddr == `SAPC_ADDR_RES) |
               (paddr == `SAPC_ADDR_IRQ) | (paddr == `SAPC_ADDR_MASK) | (paddr == `SAPC_ADDR_CNT);
    wire [1:0] irq_ev;
    assign irq_ev[`SAPC_IRQ_DONE] = sar_done;
    assign irq_ev[`SAPC_IRQ_REJ] = reject;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl_hold <= `SAPC_CTRL_RST;
            ctrl_soft <= 1'b0;
            soft_go <= 1'b0;
            irq_mask <= `SAPC_MASK_RST;
            irq_stat <= 2'h0;
            irq <= 1'b0;
        end else begin
            soft_go <= 1'b0;
            pready <= psel & ~pready;
            pslverr <= psel & ~pready & ~hit;
            // set wins over read clear
            if (rd & pready & (paddr == `SAPC_ADDR_IRQ)) begin
                irq_stat <= irq_ev;
            end else begin
                irq_stat <= irq_stat | irq_ev;
            end
            irq <= |((irq_stat | irq_ev) & irq_mask);
            if (wr & pready) begin
                if (paddr == `SAPC_ADDR_CTRL) begin
                    ctrl_hold <= pwdata[1];
                    soft_go <= pwdata[0];
                end
                if (paddr == `SAPC_ADDR_MASK) begin
                    irq_mask <= pwdata[1:0];
                end
            end
            ctrl_soft <= 1'b0;
            case (paddr)
                `SAPC_ADDR_CTRL: prdata <= {30'h0, ctrl_hold, ctrl_soft};
                `SAPC_ADDR_STAT: prdata <= {28'h0, out_en, hold, state == ST_CONV, busy_n};
                `SAPC_ADDR_RES: prdata <= {{(32-WIDTH){latch[WIDTH-1]}}, latch};
                `SAPC_ADDR_IRQ: prdata <= {30'h0, irq_stat};
                `SAPC_ADDR_MASK: prdata <= {30'h0, irq_mask};
                `SAPC_ADDR_CNT: prdata <= {16'h0, conv_cnt};
                default: prdata <= 32'h00000000;
            endcase
        end
    end
endmodule

// ### sapc_ctrl_monitor.sv
`timescale 1ns/1ps
module sapc_ctrl_monitor #(parameter WIDTH = 16) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // host pins
    input wire select_n,
    input wire read_conv,
    // outputs watched
    input wire result_lines_oe_n,
    input wire busy_n,
    input wire hold,
    input wire [WIDTH-1:0] dac_trial
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    reg [13:0] low_cnt;
    // length of the current busy low stretch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_cnt <= 14'h0;
        else
            low_cnt <= busy_n ? 14'h0 : low_cnt + 14'h1;
    end
    float_cs_a: assert property (select_n [*6] |-> result_lines_oe_n)
        else $error("data lines driven while deselected");
    float_rc_a: assert property ((!read_conv) [*6] |-> result_lines_oe_n)
        else $error("data lines driven while convert low");
    drive_on_a: assert property ((!select_n && read_conv) [*8] |-> !result_lines_oe_n)
        else $error("data lines not driven in read state");
    start_busy_a: assert property (($fell(select_n | read_conv) && busy_n) |-> ##[1:8] !busy_n)
        else $error("start strobe did not lower busy");
    busy_len_a: assert property ($rose(busy_n) |-> low_cnt >= 14'h02a0 && low_cnt <= 14'h02c0)
        else $error("busy low length wrong");
    hold_conv_a: assert property (!busy_n |-> hold)
        else $error("sample not held during conversion");
    trial_msb_a: assert property ($fell(busy_n) |-> ##[0:4] dac_trial == 16'h8000)
        else $error("first trial is not msb alone");
    restart_a: assert property (($rose(busy_n) && !select_n && !read_conv) |-> ##[1:4] !busy_n)
        else $error("no restart with both strobes low");
endmodule

// ### sapc_defs.vh
`ifndef SAPC_DEFS_VH
`define SAPC_DEFS_VH
`define SAPC_CLK_MHZ 100
`define SAPC_CONV_NS 7000
`define SAPC_ACQ_NS 2000
`define SAPC_CONV_CYC ((`SAPC_CONV_NS * `SAPC_CLK_MHZ) / 1000)
`define SAPC_ACQ_CYC ((`SAPC_ACQ_NS * `SAPC_CLK_MHZ) / 1000)
`define SAPC_ADDR_CTRL 12'h000
`define SAPC_ADDR_STAT 12'h004
`define SAPC_ADDR_RES 12'h008
`define SAPC_ADDR_IRQ 12'h00c
`define SAPC_ADDR_MASK 12'h010
`define SAPC_ADDR_CNT 12'h014
`define SAPC_CTRL_RST 1'h0
`define SAPC_MASK_RST 2'h0
`define SAPC_IRQ_DONE 0
`define SAPC_IRQ_REJ 1
`endif

// ### sapc_sar.v
`timescale 1ns/1ps
`include "sapc_defs.vh"
module sapc_sar #(
    parameter WIDTH = 16,
    parameter BIT_CYC = 43
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire start,
    output reg done,
    output reg [WIDTH-1:0] word,
    // comparator: high when sampled input at or above trial
    output reg [WIDTH-1:0] trial,
    input wire cmp_hi
);
    reg [WIDTH-1:0] bitmask;
    reg [15:0] tick;
    reg run;
    // trial word in offset binary: flip msb gives two's complement
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bitmask <= {WIDTH{1'b0}};
            trial <= {WIDTH{1'b0}};
            word <= {WIDTH{1'b0}};
            tick <= 16'h0000;
            run <= 1'b0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                run <= 1'b1;
                tick <= 16'h0000;
                bitmask <= {1'b1, {(WIDTH-1){1'b0}}};
                trial <= {1'b1, {(WIDTH-1){1'b0}}};
            end else if (run) begin
                if (tick == BIT_CYC[15:0] - 16'h0001) begin
                    tick <= 16'h0000;
                    // keep or drop current bit, try next lower
                    if (bitmask[0]) begin
                        run <= 1'b0;
                        done <= 1'b1;
                        word <= (cmp_hi ? trial : (trial & ~bitmask)) ^ {1'b1, {(WIDTH-1){1'b0}}};
                    end else begin
                        trial <= (cmp_hi ? trial : (trial & ~bitmask)) | (bitmask >> 1);
                    end
                    bitmask <= bitmask >> 1;
                end else begin
                    tick <= tick + 16'h0001;
                end
            end
        end
    end
endmodule

// ### test_sapc_ctrl.sv
`timescale 1ns/1ps
`include "sapc_defs.vh"
module test_sapc_ctrl;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, er, b;
    logic select_n = 1'h1, read_conv = 1'h1, byte_swap = 1'h0;
    logic pready, pslverr, irq, busy_n, hold, cmp_hi, result_lines_oe_n;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [15:0] result_lines, dac_trial, vin = 16'h0, lv, e;
    int err_count = 0, checks_done = 0, n;
    // 100 mhz clock
    always #5 pclk = ~pclk;
    sapc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .select_n(select_n), .read_conv(read_conv), .byte_swap(byte_swap), .result_lines(result_lines),
        .result_lines_oe_n(result_lines_oe_n), .busy_n(busy_n), .hold(hold), .dac_trial(dac_trial),
        .cmp_hi(cmp_hi));
    sapc_afe_model afe_u (.pclk(pclk), .hold(hold), .dac_trial(dac_trial), .vin(vin), .cmp_hi(cmp_hi));
    ////////////////////////////////////////
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask
    // apb transfer, answer taken at the ready edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'h1 && n < 20) begin
            @(posedge pclk);
            n++;
        end
        check(pready, 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task wait_busy(input logic lvl);
        n = 0;
        while (busy_n !== lvl && n < 8000) begin
            @(negedge pclk);
            n++;
        end
        check(busy_n, lvl);
    endtask
    task pin(input logic w, input logic v);
        @(posedge pclk);
        if (w)
            select_n <= v;
        else
            read_conv <= v;
    endtask
    function logic [15:0] code(input logic [15:0] v);
        code = v ^ 16'h8000;
    endfunction
    function logic [15:0] swp(input logic [15:0] v);
        swp = {v[7:0], v[15:8]};
    endfunction
    ////////////////////////////////////////
    // watchdog
    initial begin
        cyc(90000);
        err_count++;
        end_sim;
    end
    initial begin
        rd = $urandom(54639);
        cyc(8);
        presetn <= 1'h1;
        cyc(2);
        check(result_lines_oe_n, 1'h1);
        apb(1'h1, `SAPC_ADDR_MASK, 32'h1);
        apb(1'h0, 12'hffc, 32'h0);
        check(rd, 32'h0);
        check(er, 1'h1);
        for (int i = 0; i < 5; i++) begin
            lv = i == 0 ? 16'hfffe : i == 1 ? 16'hffff : i == 2 ? 16'h8000 : i == 3 ? 16'h7fff : $urandom;
            vin <= lv;
            e = code(lv);
            pin(!i[0], 1'h0);
            cyc(2);
            pin(i[0], 1'h0);
            cyc(5);
            wait_busy(1'h0);
            if (i != 4) begin
                pin(i[0], 1'h1);
                cyc(20);
                pin(i[0], 1'h0);
                cyc(5);
                pin(i[0], 1'h1);
                cyc(4);
                check(irq, 1'h0);
            end
            wait_busy(1'h1);
            cyc(2);
            check(irq, 1'h1);
            apb(1'h0, `SAPC_ADDR_IRQ, 32'h0);
            check(rd, i == 4 ? 32'h1 : 32'h3);
            check(busy_n, i == 4 ? 1'h0 : 1'h1);
            cyc(2);
            check(irq, 1'h0);
            apb(1'h0, `SAPC_ADDR_RES, 32'h0);
            check(rd, {{16{e[15]}}, e});
            pin(1'h0, 1'h1);
            cyc(2);
            b = $urandom & 1;
            select_n <= 1'h0;
            byte_swap <= b;
            cyc(8);
            check(result_lines_oe_n, 1'h0);
            check(result_lines, b ? swp(e) : e);
            byte_swap <= ~b;
            cyc(8);
            check(result_lines, b ? e : swp(e));
            select_n <= 1'h1;
            cyc(8);
            check(result_lines_oe_n, 1'h1);
            cyc(200);
            $display("test %0d done", i);
        end
        end_sim;
    end
endmodule
bind sapc_ctrl sapc_ctrl_monitor #(.WIDTH(WIDTH)) mon_u (.pclk(pclk), .presetn(presetn), .select_n(select_n),
    .read_conv(read_conv), .result_lines_oe_n(result_lines_oe_n), .busy_n(busy_n), .hold(hold),
    .dac_trial(dac_trial));
